// ### hdl/mon_pkg.sv
// Constants for the monitor control and interrupt block.
// Assumes a single 100 MHz clock and a byte-wide register port behind the
// serial management bus slave.
package mon_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h40;
    localparam logic [7:0] OFS_FLAGS_A = 8'h41;
    localparam logic [7:0] OFS_FLAGS_B = 8'h42;
    localparam logic [7:0] OFS_HIDE_A = 8'h43;
    localparam logic [7:0] OFS_HIDE_B = 8'h44;
    localparam logic [7:0] OFS_SPARE = 8'h45;
    localparam logic [7:0] OFS_INTR_REL = 8'h46;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_CTRL = 8'h08;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int CTRL_START = 0;
    localparam int CTRL_INT_EN = 1;
    localparam int CTRL_THERMAL_ALARM_N_EN = 2;
    localparam int CTRL_INT_CLEAR = 3;
    localparam int CTRL_RESET_PULSE = 4;
    localparam int CTRL_THERMAL_ALARM_N_GATE = 6;
    localparam int CTRL_INIT = 7;
    localparam int INTR_REL_BIT = 7;

    // ************************************************************
    // Status field layout
    // ************************************************************
    localparam logic [7:0] LIMIT_A_MASK = 8'hFF;
    localparam logic [7:0] LIMIT_B_MASK = 8'h03;
    localparam logic [7:0] THERMAL_ALARM_N_A_MASK = 8'h30;
    localparam int FLAG_B_INTRUSION = 4;
    localparam int FLAG_B_THERMAL_ALARM_N_PIN = 5;
    localparam int FLAG_B_DIODE1 = 6;
    localparam int FLAG_B_DIODE2 = 7;
    localparam logic [7:0] THERMAL_ALARM_N_B_MASK = 8'hE0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int PULSE_MS = 20;
    localparam int PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000);
endpackage : mon_pkg

// ### hdl/low_pulse_timer.sv
// One-shot active-low pulse generator of a programmable cycle length.
// Assumes start is a one-cycle request; requests during a pulse are dropped.
`timescale 1ns/1ps
`default_nettype none
module low_pulse_timer #(
    parameter int LEN = 2_000_000,
    parameter int CW = $clog2(LEN + 1)
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic start, // Begin a pulse
    output logic pulse_n_q, // Low while pulsing
    output logic done // One cycle as pulse ends
);
    typedef enum logic {IDLE = 1'b0, PULSE = 1'b1} pstate_t;

    localparam logic [CW-1:0] LAST = CW'(LEN - 1);

    pstate_t state_q;
    pstate_t state_d;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    wire at_end = (count_q == LAST);

    // Next state; a restart while busy is ignored so the width never shrinks
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        unique case (state_q)
            IDLE: begin
                count_d = '0;
                if (start) begin
                    state_d = PULSE;
                end
            end
            PULSE: begin
                count_d = count_q + CW'(1);
                if (at_end) begin
                    state_d = IDLE;
                end
            end
        endcase
    end

    assign done = (state_q == PULSE) && at_end;

    // State and pin flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= IDLE;
            count_q <= '0;
            pulse_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            pulse_n_q <= (state_d != PULSE);
        end
    end
endmodule : low_pulse_timer
`default_nettype wire

// ### hdl/monitor_interrupt_control.sv
// Control and interrupt section of the hardware monitor.
// Assumes the serial bus slave presents one-cycle byte read/write strobes
// and the conversion datapath supplies one-cycle limit-violation events.
//
// Behaviour
// R1: Control bit 0 starts monitoring; zero puts the part in standby.
// R2: Clearing start keeps already asserted interrupt pins asserted.
// R3: Running monitoring scans channels and compares against limits.
// R4: Host should program all limits before setting start.
// R5: Control bit 1 enables general interrupt; zero keeps it inactive.
// R6: Control bit 2 enables thermal alarm; zero keeps it inactive.
// R7: Bit 3 drops general interrupt, suspends monitoring, keeps status.
// R8: Bit 4 drives 20 ms low reset pulse, then self-clears.
// R9: Bit 6 drops thermal alarm output, status untouched.
// R10: Bit 7 restores power-on values and reads back zero; the spare register keeps its value.
// R11: Voltage/temperature flags set on high or low limit violation.
// R12: Flags A6/A7 set on tach count or auxiliary analog limit.
// R13: Flag B4 set when chassis intrusion input goes high.
// R14: Flag B5 set when outside circuitry pulls thermal pin low.
// R15: Flags B6/B7 report remote diode one and two faults.
// R16: Mask bit one hides matching status bit from general interrupt.
// R17: Spare register resets zero, holds whatever host writes.
// R18: Intrusion release bit 7 drives 20 ms low pulse, self-clears.
// R19: Thermal interrupt mask keeps thermal events off general interrupt.
// R20: General interrupt low when unmasked flag set, enabled, not cleared.
`timescale 1ns/1ps
`default_nettype none
module monitor_interrupt_control
    import mon_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES
) (
    input wire logic mclk, // 100 MHz clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [7:0] reg_addr, // Register pointer
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, held
    input wire logic [7:0] limit_event_a, // Datapath violations, group A
    input wire logic [1:0] limit_event_b, // Datapath violations, group B
    input wire logic tach_or_analog_one, // Channel 6 in analog mode
    input wire logic tach_or_analog_two, // Channel 7 in analog mode
    input wire logic remote_diode_one_fault, // Diode one short/open
    input wire logic remote_diode_two_fault, // Diode two short/open
    input wire logic thermal_alarm_n_event, // Thermal limit crossed
    input wire logic thermal_alarm_n_int_mask, // Thermal events off general irq
    input wire logic chassis_intrusion_i, // Intrusion pin level
    output logic chassis_intrusion_o, // Intrusion pin drive value
    output logic chassis_intrusion_oe, // Intrusion pin drive enable
    input wire logic thermal_alarm_n_i, // Thermal pin level
    output logic thermal_alarm_n_o, // Thermal pin drive value
    output logic thermal_alarm_n_oe, // Thermal pin drive enable
    output logic int_n, // General interrupt, low active
    output logic reset_out_n, // Timed reset, low active
    output logic scan_run, // Datapath may scan and compare
    output logic init_pulse // Re-init for outside registers
);
    // ************************************************************
    // Register state
    // ************************************************************
    logic [7:0] ctrl_q;
    logic [7:0] flags_a_q;
    logic [7:0] flags_b_q;
    logic [7:0] hide_a_q;
    logic [7:0] hide_b_q;
    logic [7:0] spare_q;
    logic [7:0] intr_rel_q;
    logic [7:0] ctrl_d;
    logic [7:0] intr_rel_d;
    logic [7:0] flags_a_d;
    logic [7:0] flags_b_d;
    logic intrusion_prev_q;
    logic intr_drive_q;
    logic thermal_alarm_n_drive_q;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire hit_ctrl = (reg_addr == OFS_CTRL);
    wire hit_fa = (reg_addr == OFS_FLAGS_A);
    wire hit_fb = (reg_addr == OFS_FLAGS_B);
    wire hit_ha = (reg_addr == OFS_HIDE_A);
    wire hit_hb = (reg_addr == OFS_HIDE_B);
    wire hit_spare = (reg_addr == OFS_SPARE);
    wire hit_rel = (reg_addr == OFS_INTR_REL);
    wire wr_ctrl = reg_wr && hit_ctrl;
    // R10 restore defaults
    wire init_req = wr_ctrl && reg_wdata[CTRL_INIT];
    wire rd_fa = reg_rd && hit_fa;
    wire rd_fb = reg_rd && hit_fb;

    // ************************************************************
    // Pulse timers
    // ************************************************************
    wire rst_start = wr_ctrl && !init_req && reg_wdata[CTRL_RESET_PULSE]
        && !ctrl_q[CTRL_RESET_PULSE];
    wire rel_start = reg_wr && hit_rel && reg_wdata[INTR_REL_BIT]
        && !intr_rel_q[INTR_REL_BIT];
    wire rst_done;
    wire rel_done;
    wire rel_pulse_n;

    // R8 timed reset pulse
    low_pulse_timer #(.LEN(PULSE_LEN)) u_reset_pulse (
        .mclk(mclk),
        .rst(rst),
        .start(rst_start),
        .pulse_n_q(reset_out_n),
        .done(rst_done)
    );

    // R18 intrusion release pulse
    low_pulse_timer #(.LEN(PULSE_LEN)) u_release_pulse (
        .mclk(mclk),
        .rst(rst),
        .start(rel_start),
        .pulse_n_q(rel_pulse_n),
        .done(rel_done)
    );

    // ************************************************************
    // Control and release register next values
    // ************************************************************
    // R8 self-clear; a pending pulse bit survives a host rewrite
    always_comb begin
        ctrl_d = ctrl_q;
        if (init_req) begin
            ctrl_d = RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_d = reg_wdata;
            ctrl_d[CTRL_INIT] = 1'b0;
            ctrl_d[CTRL_RESET_PULSE] = ctrl_q[CTRL_RESET_PULSE]
                || reg_wdata[CTRL_RESET_PULSE];
        end
        if (rst_done) begin
            ctrl_d[CTRL_RESET_PULSE] = 1'b0;
        end
    end

    // R18 bit self-clears as the release timer ends, one cycle before the pin is let go
    always_comb begin
        intr_rel_d = intr_rel_q;
        if (init_req) begin
            intr_rel_d = RST_ZERO;
        end else if (reg_wr && hit_rel) begin
            intr_rel_d = reg_wdata;
            intr_rel_d[INTR_REL_BIT] = intr_rel_q[INTR_REL_BIT]
                || reg_wdata[INTR_REL_BIT];
        end
        if (rel_done) begin
            intr_rel_d[INTR_REL_BIT] = 1'b0;
        end
    end

    // ************************************************************
    // Event sources
    // ************************************************************
    // R1 R3 R7 scanning runs only when started and not suspended
    wire run_d = ctrl_d[CTRL_START] && !ctrl_d[CTRL_INT_CLEAR];
    wire running = ctrl_q[CTRL_START] && !ctrl_q[CTRL_INT_CLEAR];
    // R11 R12 limit events count only while scanning
    wire [7:0] ev_a = running ? (limit_event_a & LIMIT_A_MASK) : RST_ZERO;
    wire [1:0] ev_b = running ? limit_event_b : 2'h0;
    // R13 rising intrusion level, ignored while we pull the pin
    wire intr_rise = chassis_intrusion_i && !intrusion_prev_q
        && !intr_drive_q;
    // R14 pin low while we are not driving it
    wire thermal_alarm_n_ext = !thermal_alarm_n_i && !thermal_alarm_n_drive_q;
    wire [7:0] ev_b_full = {remote_diode_two_fault, remote_diode_one_fault,
        thermal_alarm_n_ext, intr_rise, 2'h0, ev_b};

    // ************************************************************
    // Status flags: a read clears, a new event in that cycle wins
    // ************************************************************
    always_comb begin
        flags_a_d = rd_fa ? RST_ZERO : flags_a_q;
        flags_b_d = rd_fb ? RST_ZERO : flags_b_q;
        // R11 R12 limit latches
        flags_a_d = flags_a_d | ev_a;
        // R13 R14 R15 external and diode latches
        flags_b_d = flags_b_d | ev_b_full;
        if (init_req) begin
            flags_a_d = RST_ZERO;
            flags_b_d = RST_ZERO;
        end
    end

    // ************************************************************
    // Interrupt combining
    // ************************************************************
    // R16 mask hides a flag
    wire [7:0] vis_a = flags_a_d & ~hide_a_q;
    wire [7:0] vis_b = flags_b_d & ~hide_b_q;
    // R19 thermal sources dropped from general interrupt on request
    wire [7:0] tm_a = thermal_alarm_n_int_mask ? ~THERMAL_ALARM_N_A_MASK : 8'hFF;
    wire [7:0] tm_b = thermal_alarm_n_int_mask ? ~THERMAL_ALARM_N_B_MASK : 8'hFF;
    wire any_vis = |(vis_a & tm_a) || |(vis_b & tm_b);
    // R20 R5 R7 general interrupt; R2 flags hold it across standby
    wire int_act = any_vis && ctrl_d[CTRL_INT_EN]
        && !ctrl_d[CTRL_INT_CLEAR];
    // R6 R9 thermal alarm drive
    wire thermal_alarm_n_act = thermal_alarm_n_event && ctrl_d[CTRL_THERMAL_ALARM_N_EN]
        && !ctrl_d[CTRL_THERMAL_ALARM_N_GATE];

    // ************************************************************
    // Read mux, unmapped offsets read zero
    // ************************************************************
    wire [7:0] rd_mux =
        hit_ctrl ? ctrl_q :
        hit_fa ? flags_a_q :
        hit_fb ? flags_b_q :
        hit_ha ? hide_a_q :
        hit_hb ? hide_b_q :
        hit_spare ? spare_q :
        hit_rel ? intr_rel_q : RST_ZERO;

    // ************************************************************
    // Register flops
    // ************************************************************
    // Host registers; spare is not in the restore list, so init skips it
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q <= RST_CTRL;
            intr_rel_q <= RST_ZERO;
            hide_a_q <= RST_ZERO;
            hide_b_q <= RST_ZERO;
            spare_q <= RST_ZERO;
        end else begin
            ctrl_q <= ctrl_d;
            intr_rel_q <= intr_rel_d;
            // R16 mask registers
            hide_a_q <= init_req ? RST_ZERO
                : (reg_wr && hit_ha) ? reg_wdata : hide_a_q;
            hide_b_q <= init_req ? RST_ZERO
                : (reg_wr && hit_hb) ? reg_wdata : hide_b_q;
            // R17 plain storage
            spare_q <= (reg_wr && hit_spare) ? reg_wdata : spare_q;
        end
    end

    // Status flags and edge history
    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_a_q <= RST_ZERO;
            flags_b_q <= RST_ZERO;
            intrusion_prev_q <= 1'b0;
        end else begin
            flags_a_q <= flags_a_d;
            flags_b_q <= flags_b_d;
            intrusion_prev_q <= chassis_intrusion_i;
        end
    end

    // Registered outputs, so the pins never glitch on decode
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= RST_ZERO;
            int_n <= 1'b1;
            thermal_alarm_n_drive_q <= 1'b0;
            intr_drive_q <= 1'b0;
            scan_run <= 1'b0;
            init_pulse <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : reg_rdata;
            int_n <= !int_act;
            thermal_alarm_n_drive_q <= thermal_alarm_n_act;
            intr_drive_q <= !rel_start && rel_pulse_n ? 1'b0 : 1'b1;
            // R3 datapath enable
            scan_run <= run_d;
            init_pulse <= init_req;
        end
    end

    // Open-drain pins: value is low, enable carries the drive
    assign thermal_alarm_n_o = 1'b0;
    assign thermal_alarm_n_oe = thermal_alarm_n_drive_q;
    assign chassis_intrusion_o = 1'b0;
    assign chassis_intrusion_oe = intr_drive_q;
endmodule : monitor_interrupt_control
`default_nettype wire

// ### test/mon_ctrl_chk.sv
// Port checker for the monitor control and interrupt block.
// Assumes the bind below hands on the shortened pulse length.
`timescale 1ns/1ps
`default_nettype none
module mon_ctrl_chk
    import mon_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES
) (
    input wire logic mclk, // Clock
    input wire logic rst, // Sync reset
    input wire logic [7:0] reg_addr, // Pointer
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic thermal_alarm_n_event, // Thermal limit
    input wire logic chassis_intrusion_oe, // Intrusion drive
    input wire logic thermal_alarm_n_oe, // Alarm drive
    input wire logic int_n, // General irq
    input wire logic reset_out_n, // Timed reset
    input wire logic scan_run, // Scanning
    input wire logic init_pulse // Re-init
);
    // ************************************************************
    // Shadow state
    // ************************************************************
    logic [7:0] ctl_q;
    logic [7:0] spare_q;
    int low_q;
    int oe_q;
    // Decoded views of the mirrored control byte
    wire ctl_wr = reg_wr && reg_addr == OFS_CTRL;
    // Byte in force after this edge; the block acts on a write at once
    wire [7:0] ctl_nx = !ctl_wr ? ctl_q
        : reg_wdata[CTRL_INIT] ? RST_CTRL : reg_wdata;
    wire irq_off = !ctl_nx[CTRL_INT_EN] || ctl_nx[CTRL_INT_CLEAR];
    wire alarm_off = !ctl_nx[CTRL_THERMAL_ALARM_N_EN] || ctl_nx[CTRL_THERMAL_ALARM_N_GATE];
    wire scan_on = ctl_nx[CTRL_START] && !ctl_nx[CTRL_INT_CLEAR];

    // Mirror host writes; pulse widths are counted, not trusted
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_q <= RST_CTRL;
            spare_q <= RST_ZERO;
            low_q <= 0;
            oe_q <= 0;
        end else begin
            if (ctl_wr) begin
                ctl_q <= reg_wdata[CTRL_INIT] ? RST_CTRL : reg_wdata;
            end
            if (reg_wr && reg_addr == OFS_SPARE) begin
                spare_q <= reg_wdata;
            end
            low_q <= reset_out_n ? 0 : low_q + 1;
            oe_q <= chassis_intrusion_oe ? oe_q + 1 : 0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    rst_len_a: assert property (
        $rose(reset_out_n) |-> low_q == PULSE_LEN) else $error("bad reset width");
    // Init wins over a pulse request in the same byte
    rst_go_a: assert property (
        ctl_wr && reg_wdata[CTRL_RESET_PULSE] && !reg_wdata[CTRL_INIT]
        && reset_out_n |=> !reset_out_n)
        else $error("reset pulse not started");
    // Pin drive starts on the write edge with the timer and ends one cycle after it
    ci_len_a: assert property (
        $fell(chassis_intrusion_oe) |-> oe_q == PULSE_LEN + 1)
        else $error("bad intrusion pulse width");
    irq_gate_a: assert property (
        irq_off |=> int_n) else $error("irq active while gated");
    alarm_gate_a: assert property (
        alarm_off |=> !thermal_alarm_n_oe) else $error("alarm while gated");
    alarm_cause_a: assert property (
        $rose(thermal_alarm_n_oe) |-> $past(thermal_alarm_n_event))
        else $error("alarm without thermal event");
    spare_rd_a: assert property (
        reg_rd && !reg_wr && reg_addr == OFS_SPARE |=>
        reg_rdata == $past(spare_q)) else $error("spare readback wrong");
    init_go_a: assert property (
        ctl_wr && reg_wdata[CTRL_INIT] |=> init_pulse) else $error("no init");
    scan_on_a: assert property (
        scan_on |=> scan_run) else $error("scan not running");
    scan_off_a: assert property (
        !scan_on |=> !scan_run) else $error("scan running in standby");

    cover property ($fell(reset_out_n));
    cover property ($rose(chassis_intrusion_oe));
    cover property ($fell(int_n));
    cover property (init_pulse);
endmodule : mon_ctrl_chk

bind monitor_interrupt_control mon_ctrl_chk #(
    .PULSE_LEN(PULSE_LEN)
) mon_ctrl_chk_i (
    .mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .thermal_alarm_n_event, .chassis_intrusion_oe, .thermal_alarm_n_oe, .int_n,
    .reset_out_n, .scan_run, .init_pulse
);
`default_nettype wire

// ### test/pin_env.sv
// Board around the two open-drain pins of the monitor block.
// Assumes the alarm wire has a pull-up; the intrusion switch drives.
`timescale 1ns/1ps
`default_nettype none
module pin_env (
    input wire logic intr_o, // Block drive value, intrusion
    input wire logic intr_oe, // Block drives intrusion
    input wire logic alarm_o, // Block drive value, alarm
    input wire logic alarm_oe, // Block drives alarm
    input wire logic intr_ext, // Intrusion switch level
    input wire logic alarm_pull, // Outside part pulls alarm low
    output logic intr_pin, // Resolved intrusion wire
    output logic alarm_pin // Resolved alarm wire
);
    assign intr_pin = intr_oe ? intr_o : intr_ext;
    assign alarm_pin = alarm_oe ? alarm_o : !alarm_pull;
endmodule : pin_env
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the monitor control and interrupt block.
// Assumes a plain byte register port and a pulse length of 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import mon_pkg::*;
;
    logic mclk, rst, reg_wr, reg_rd, d1, d2, thermal_alarm_n_event, tmask;
    logic intr_ext, alarm_pull, intr_o, intr_oe, alarm_o, alarm_oe;
    logic int_n, reset_out_n, scan_run, init_pulse, intr_pin, alarm_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ev_a;
    logic [1:0] ev_b;
    int num_errors = 0;
    int checked = 0;

    monitor_interrupt_control #(.PULSE_LEN(8)) monitor_interrupt_control_i (
        .mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .limit_event_a(ev_a), .limit_event_b(ev_b),
        .tach_or_analog_one(1'b0), .tach_or_analog_two(1'b0),
        .remote_diode_one_fault(d1), .remote_diode_two_fault(d2),
        .thermal_alarm_n_event, .thermal_alarm_n_int_mask(tmask),
        .chassis_intrusion_i(intr_pin), .chassis_intrusion_o(intr_o),
        .chassis_intrusion_oe(intr_oe), .thermal_alarm_n_i(alarm_pin),
        .thermal_alarm_n_o(alarm_o), .thermal_alarm_n_oe(alarm_oe),
        .int_n, .reset_out_n, .scan_run, .init_pulse);
    pin_env pin_env_i (.intr_o, .intr_oe, .alarm_o, .alarm_oe, .intr_ext,
        .alarm_pull, .intr_pin, .alarm_pin);

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : wr
    // Read data is registered: compare one edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        chk(reg_rdata, exp);
        tick(1);
    endtask : rd
    task automatic ev(input logic [7:0] a, input logic [1:0] b);
        ev_a = a;
        ev_b = b;
        tick(1);
        ev_a = 8'h00;
        ev_b = 2'h0;
        tick(1);
    endtask : ev
    // Bounded wait for a timed pulse to finish
    task automatic wait_end(input logic sel);
        int n = 0;
        while ((sel ? intr_oe : !reset_out_n) && n < 40) begin
            tick(1);
            n++;
        end
        if (n >= 40) begin
            num_errors++;
            $display("[ERR] %0t pulse never ended", $time);
            print_verdict();
        end
    endtask : wait_end
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {rst, reg_wr, reg_rd, d1, d2, thermal_alarm_n_event, tmask} = 7'h40;
        {intr_ext, alarm_pull, reg_addr, reg_wdata, ev_a, ev_b} = 28'h0;
        tick(6);
        rst = 1'b0;
        // power-on values, unmapped 47 reads zero
        for (int i = 0; i < 8; i++) begin
            rd(8'h40 + 8'(i), (i == 0) ? RST_CTRL : RST_ZERO);
        end
        wr(OFS_FLAGS_A, 8'hFF);
        rd(OFS_FLAGS_A, 8'h00);
        wr(OFS_SPARE, 8'hA5);
        rd(OFS_SPARE, 8'hA5);
        wr(OFS_HIDE_A, 8'h01);
        rd(OFS_HIDE_A, 8'h01);
        // limits live in the datapath, so start is set last
        wr(OFS_CTRL, 8'h01);
        chk(8'(scan_run), 8'h01);
        ev(8'h02, 2'h0);
        chk(8'(int_n), 8'h01);
        rd(OFS_FLAGS_A, 8'h02);
        wr(OFS_CTRL, 8'h03);
        ev(8'h01, 2'h0);
        chk(8'(int_n), 8'h01);
        ev(8'h80, 2'h0);
        chk(8'(int_n), 8'h00);
        wr(OFS_CTRL, 8'h0B);
        chk(8'(int_n), 8'h01);
        chk(8'(scan_run), 8'h00);
        ev(8'h04, 2'h0);
        rd(OFS_FLAGS_A, 8'h81);
        wr(OFS_CTRL, 8'h03);
        ev(8'h00, 2'h1);
        wr(OFS_CTRL, 8'h02);
        chk(8'(int_n), 8'h00);
        rd(OFS_FLAGS_B, 8'h01);
        chk(8'(int_n), 8'h01);
        // thermal sources kept off the interrupt
        tmask = 1'b1;
        d1 = 1'b1;
        tick(1);
        d1 = 1'b0;
        tick(2);
        chk(8'(int_n), 8'h01);
        tmask = 1'b0;
        tick(2);
        chk(8'(int_n), 8'h00);
        rd(OFS_FLAGS_B, 8'h40);
        wr(OFS_CTRL, 8'h00);
        {intr_ext, alarm_pull, d2} = 3'h7;
        tick(2);
        {intr_ext, alarm_pull, d2} = 3'h0;
        rd(OFS_FLAGS_B, 8'hB0);
        thermal_alarm_n_event = 1'b1;
        tick(2);
        chk(8'(alarm_oe), 8'h00);
        wr(OFS_CTRL, 8'h04);
        chk(8'(alarm_oe), 8'h01);
        wr(OFS_CTRL, 8'h44);
        chk(8'(alarm_oe), 8'h00);
        thermal_alarm_n_event = 1'b0;
        rd(OFS_FLAGS_B, 8'h00);
        wr(OFS_CTRL, 8'h10);
        chk(8'(reset_out_n), 8'h00);
        rd(OFS_CTRL, 8'h10);
        wait_end(1'b0);
        rd(OFS_CTRL, 8'h00);
        wr(OFS_INTR_REL, 8'h80);
        chk(8'(intr_pin), 8'h00);
        wait_end(1'b1);
        rd(OFS_INTR_REL, 8'h00);
        rd(OFS_FLAGS_B, 8'h00);
        // re-init; spare is outside the restore list
        wr(OFS_HIDE_B, 8'hFF);
        wr(OFS_CTRL, 8'h80);
        tick(1);
        rd(OFS_CTRL, RST_CTRL);
        rd(OFS_HIDE_B, 8'h00);
        rd(OFS_HIDE_A, 8'h00);
        rd(OFS_SPARE, 8'hA5);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
